// ==== design/gct_channel.sv ====
// Purpose: one counter/timer channel: count bytes, overflow flag, irq
// Assumes: step_in is a one-cycle increment request already gated
// Notes:   software byte writes override counting in the same cycle
`timescale 1ns/10ps
module gct_channel (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [1:0] mode_in,
	input  wire logic       step_in,
	input  wire logic       low_wr_in,
	input  wire logic       high_wr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       flag_clr_in,
	input  wire logic       irq_en_in,
	output logic      [7:0] low_byte_out,
	output logic      [7:0] high_byte_out,
	output logic            flag_out,
	output logic            irq_out
);
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       flag;
		logic       irq;
	} gct_chan_s;

	gct_chan_s st;
	gct_chan_s next_st;
	logic [15:0] sum;
	logic        wrap;

	function automatic logic [15:0] gct_incr(input logic [15:0] v);
		gct_incr = v + gct_pkg::CNT_ONE;
	endfunction

	always_comb begin
		next_st = st;
		wrap = 1'b0;
		sum = gct_pkg::CNT_ZERO;
		if (step_in) begin
			unique case (mode_in)
				gct_pkg::MODE_13: begin
					sum = gct_incr({3'h0, st.high, st.low[gct_pkg::LOW13_W-1:0]});
					next_st.low[gct_pkg::LOW13_W-1:0] = sum[gct_pkg::LOW13_W-1:0];
					next_st.high = sum[12:gct_pkg::LOW13_W];
					wrap = (st.high == gct_pkg::BYTE_ONES) &&
						(st.low[gct_pkg::LOW13_W-1:0] == gct_pkg::LOW5_ONES);
				end
				gct_pkg::MODE_16: begin
					sum = gct_incr({st.high, st.low});
					next_st.low = sum[7:0];
					next_st.high = sum[15:8];
					wrap = ({st.high, st.low} == gct_pkg::CNT_ONES);
				end
				gct_pkg::MODE_8R: begin
					sum = gct_incr({gct_pkg::BYTE_RST, st.low});
					wrap = (st.low == gct_pkg::BYTE_ONES);
					next_st.low = wrap ? st.high : sum[7:0];
				end
				gct_pkg::MODE_SPLIT: begin
					next_st = st;
				end
			endcase
		end
		if (low_wr_in) begin
			next_st.low = wr_data_in;
		end
		if (high_wr_in) begin
			next_st.high = wr_data_in;
		end
		if (flag_clr_in) begin
			next_st.flag = 1'b0;
		end
		if (wrap) begin
			next_st.flag = 1'b1;
		end
		next_st.irq = next_st.flag & irq_en_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign low_byte_out  = st.low;
	assign high_byte_out = st.high;
	assign flag_out      = st.flag;
	assign irq_out       = st.irq;
endmodule

// ==== design/gct_top.sv ====
// Purpose: two gated counter/timers with pin synchronisers and prescaler
// Assumes: all control bits are held by software on plain ports
// Notes:   mode 3 (split) holds the count; external osc divided by 8
`timescale 1ns/10ps
module gct_top (
	input  wire logic       ref_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       event_pin_a_in,
	input  wire logic       event_pin_b_in,
	input  wire logic       gate_input_a_in,
	input  wire logic       gate_input_b_in,
	input  wire logic       gate_input_a_polarity_in,
	input  wire logic       gate_input_b_polarity_in,
	input  wire logic       ext_osc_in,
	input  wire logic [1:0] prescale_select_in,
	input  wire logic [1:0] timer0_mode_in,
	input  wire logic       timer0_counter_select_in,
	input  wire logic       timer0_gate_en_in,
	input  wire logic       timer0_run_in,
	input  wire logic       timer0_fastclk_sel_in,
	input  wire logic       timer0_irq_en_in,
	input  wire logic       timer0_low_wr_in,
	input  wire logic       timer0_high_wr_in,
	input  wire logic [7:0] timer0_wr_data_in,
	input  wire logic       timer0_flag_clr_in,
	input  wire logic [1:0] timer1_mode_in,
	input  wire logic       timer1_counter_select_in,
	input  wire logic       timer1_gate_en_in,
	input  wire logic       timer1_run_in,
	input  wire logic       timer1_fastclk_sel_in,
	input  wire logic       timer1_irq_en_in,
	input  wire logic       timer1_low_wr_in,
	input  wire logic       timer1_high_wr_in,
	input  wire logic [7:0] timer1_wr_data_in,
	input  wire logic       timer1_flag_clr_in,
	output logic      [7:0] timer0_low_byte_out,
	output logic      [7:0] timer0_high_byte_out,
	output logic            timer0_overflow_flag_out,
	output logic            timer0_irq_out,
	output logic      [7:0] timer1_low_byte_out,
	output logic      [7:0] timer1_high_byte_out,
	output logic            timer1_overflow_flag_out,
	output logic            timer1_irq_out
);
	typedef struct packed {
		logic [gct_pkg::SYN_N-1:0][gct_pkg::SYN_D-1:0] sync;
		logic [gct_pkg::SYN_N-1:0]                     level;
		logic [1:0]                                    fall;
		logic                                          ext_rise;
		logic [gct_pkg::PSC_W-1:0]                     presc_cnt;
		logic [1:0]                                    presc_sel;
		logic                                          presc_tick;
	} gct_top_s;

	gct_top_s st;
	gct_top_s next_st;

	logic [gct_pkg::SYN_N-1:0] pin_vec;
	logic                      gate_act_a;
	logic                      gate_act_b;
	logic                      step0;
	logic                      step1;
	logic                      presc_adv;
	logic [gct_pkg::PSC_W-1:0] presc_lim;
	logic [15:0]               t0_count;
	logic [15:0]               t1_count;
	logic [4:0]                t0_low5;
	logic [4:0]                t1_low5;
	logic                      t0_nowr;
	logic                      t1_nowr;

	function automatic logic [gct_pkg::PSC_W-1:0] gct_presc_limit(input logic [1:0] sel);
		unique case (sel)
			gct_pkg::PSC_DIV12: gct_presc_limit = gct_pkg::LIM_DIV12;
			gct_pkg::PSC_DIV4:  gct_presc_limit = gct_pkg::LIM_DIV4;
			gct_pkg::PSC_DIV48: gct_presc_limit = gct_pkg::LIM_DIV48;
			gct_pkg::PSC_EXT8:  gct_presc_limit = gct_pkg::LIM_EXT8;
		endcase
	endfunction

	function automatic logic gct_step(
		input logic run,
		input logic gate_en,
		input logic gate_act,
		input logic csel,
		input logic fast,
		input logic fall,
		input logic tick
	);
		gct_step = run && (!gate_en || gate_act) && (csel ? fall : (fast || tick));
	endfunction

	assign pin_vec = {ext_osc_in, gate_input_b_in, gate_input_a_in,
		event_pin_b_in, event_pin_a_in};

	always_comb begin
		next_st = st;
		presc_lim = gct_presc_limit(st.presc_sel);
		for (int i = 0; i < gct_pkg::SYN_N; i++) begin
			next_st.sync[i] = {st.sync[i][gct_pkg::SYN_S2:gct_pkg::SYN_S1], pin_vec[i]};
			if (st.sync[i][gct_pkg::SYN_S2] == st.sync[i][gct_pkg::SYN_S3]) begin
				next_st.level[i] = st.sync[i][gct_pkg::SYN_S3];
			end
		end
		next_st.fall[0] = st.level[gct_pkg::SYN_EVA] & ~next_st.level[gct_pkg::SYN_EVA];
		next_st.fall[1] = st.level[gct_pkg::SYN_EVB] & ~next_st.level[gct_pkg::SYN_EVB];
		next_st.ext_rise = ~st.level[gct_pkg::SYN_EXT] & next_st.level[gct_pkg::SYN_EXT];
		presc_adv = (st.presc_sel == gct_pkg::PSC_EXT8) ? st.ext_rise : 1'b1;
		next_st.presc_sel = prescale_select_in;
		next_st.presc_tick = 1'b0;
		if (prescale_select_in != st.presc_sel) begin
			next_st.presc_cnt = gct_pkg::PSC_RST;
		end else if (presc_adv) begin
			if (st.presc_cnt == presc_lim) begin
				next_st.presc_cnt = gct_pkg::PSC_RST;
				next_st.presc_tick = 1'b1;
			end else begin
				next_st.presc_cnt = st.presc_cnt + gct_pkg::PSC_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign gate_act_a = (st.level[gct_pkg::SYN_GTA] == gate_input_a_polarity_in);
	assign gate_act_b = (st.level[gct_pkg::SYN_GTB] == gate_input_b_polarity_in);

	assign step0 = gct_step(timer0_run_in, timer0_gate_en_in, gate_act_a,
		timer0_counter_select_in, timer0_fastclk_sel_in, st.fall[0], st.presc_tick);
	assign step1 = gct_step(timer1_run_in, timer1_gate_en_in, gate_act_b,
		timer1_counter_select_in, timer1_fastclk_sel_in, st.fall[1], st.presc_tick);

	gct_channel u_timer0 (
		.clk_in        (ref_clk_in),
		.rst_in        (sys_rst_in),
		.mode_in       (timer0_mode_in),
		.step_in       (step0),
		.low_wr_in     (timer0_low_wr_in),
		.high_wr_in    (timer0_high_wr_in),
		.wr_data_in    (timer0_wr_data_in),
		.flag_clr_in   (timer0_flag_clr_in),
		.irq_en_in     (timer0_irq_en_in),
		.low_byte_out  (timer0_low_byte_out),
		.high_byte_out (timer0_high_byte_out),
		.flag_out      (timer0_overflow_flag_out),
		.irq_out       (timer0_irq_out)
	);

	gct_channel u_timer1 (
		.clk_in        (ref_clk_in),
		.rst_in        (sys_rst_in),
		.mode_in       (timer1_mode_in),
		.step_in       (step1),
		.low_wr_in     (timer1_low_wr_in),
		.high_wr_in    (timer1_high_wr_in),
		.wr_data_in    (timer1_wr_data_in),
		.flag_clr_in   (timer1_flag_clr_in),
		.irq_en_in     (timer1_irq_en_in),
		.low_byte_out  (timer1_low_byte_out),
		.high_byte_out (timer1_high_byte_out),
		.flag_out      (timer1_overflow_flag_out),
		.irq_out       (timer1_irq_out)
	);

	// helper views for the checks below
	assign t0_count = {timer0_high_byte_out, timer0_low_byte_out};
	assign t1_count = {timer1_high_byte_out, timer1_low_byte_out};
	assign t0_low5  = timer0_low_byte_out[gct_pkg::LOW13_W-1:0];
	assign t1_low5  = timer1_low_byte_out[gct_pkg::LOW13_W-1:0];
	assign t0_nowr  = !timer0_low_wr_in && !timer0_high_wr_in;
	assign t1_nowr  = !timer1_low_wr_in && !timer1_high_wr_in;

	default clocking gct_cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	AST_T0_HOLD_IDLE: assert property (
		!timer0_run_in && t0_nowr |=> $stable(t0_count))
		else $error("timer 0 count moved while stopped");

	AST_T1_GATE_HOLD: assert property (
		timer1_run_in && timer1_gate_en_in && !gate_act_b && t1_nowr
		|=> $stable(t1_count))
		else $error("timer 1 counted with its gate inactive");

	AST_T0_GATE_RUN: assert property (
		timer0_run_in && timer0_gate_en_in && gate_act_a && !timer0_counter_select_in
		&& timer0_fastclk_sel_in && timer0_mode_in == gct_pkg::MODE_16 && t0_nowr
		|=> t0_count == $past(t0_count) + gct_pkg::CNT_ONE)
		else $error("timer 0 did not count with gate active");

	AST_T0_FAST16: assert property (
		timer0_run_in && !timer0_gate_en_in && !timer0_counter_select_in
		&& timer0_fastclk_sel_in && timer0_mode_in == gct_pkg::MODE_16 && t0_nowr
		|=> t0_count == $past(t0_count) + gct_pkg::CNT_ONE)
		else $error("timer 0 16-bit fast count wrong");

	AST_T0_WRAP16: assert property (
		step0 && timer0_mode_in == gct_pkg::MODE_16 && t0_count == gct_pkg::CNT_ONES
		&& t0_nowr |=> t0_count == gct_pkg::CNT_ZERO && timer0_overflow_flag_out)
		else $error("timer 0 16-bit wrap wrong");

	AST_T0_WRAP13: assert property (
		step0 && timer0_mode_in == gct_pkg::MODE_13 && t0_nowr
		&& timer0_high_byte_out == gct_pkg::BYTE_ONES && t0_low5 == gct_pkg::LOW5_ONES
		|=> timer0_high_byte_out == gct_pkg::BYTE_RST && t0_low5 == 5'h00
		&& timer0_overflow_flag_out)
		else $error("timer 0 13-bit wrap wrong");

	AST_T0_COUNT13: assert property (
		step0 && timer0_mode_in == gct_pkg::MODE_13 && t0_nowr
		&& t0_low5 != gct_pkg::LOW5_ONES
		|=> $stable(timer0_high_byte_out) && t0_low5 == $past(t0_low5) + gct_pkg::LOW5_ONE)
		else $error("timer 0 13-bit low field count wrong");

	AST_T1_RELOAD: assert property (
		step1 && timer1_mode_in == gct_pkg::MODE_8R && t1_nowr
		&& timer1_low_byte_out == gct_pkg::BYTE_ONES
		|=> timer1_low_byte_out == $past(timer1_high_byte_out) && timer1_overflow_flag_out)
		else $error("timer 1 auto-reload wrong");

	AST_T1_RELOAD_KEEP: assert property (
		timer1_mode_in == gct_pkg::MODE_8R && !timer1_high_wr_in
		|=> $stable(timer1_high_byte_out))
		else $error("timer 1 reload value changed");

	AST_T0_EVENT_ONLY: assert property (
		timer0_run_in && !timer0_gate_en_in && timer0_counter_select_in
		&& !st.fall[0] && t0_nowr |=> $stable(t0_count))
		else $error("timer 0 counted without an event edge");

	AST_T0_SET_WINS: assert property (
		step0 && timer0_flag_clr_in && timer0_mode_in == gct_pkg::MODE_16
		&& t0_count == gct_pkg::CNT_ONES |=> timer0_overflow_flag_out)
		else $error("timer 0 overflow lost against clear");

	AST_T1_IRQ: assert property (
		timer1_irq_out == (timer1_overflow_flag_out && $past(timer1_irq_en_in)))
		else $error("timer 1 interrupt request mismatch");

	AST_PRESC_DIV4: assert property (
		st.presc_tick && prescale_select_in == gct_pkg::PSC_DIV4
		&& st.presc_sel == gct_pkg::PSC_DIV4
		##1 (prescale_select_in == gct_pkg::PSC_DIV4)[*4] |-> st.presc_tick)
		else $error("prescaled tick not every four cycles");

	AST_PRESC_GAP: assert property (
		st.presc_tick |=> !st.presc_tick [*3])
		else $error("prescaled ticks too close");

	AST_T1_HOLD_IDLE: assert property (
		!timer1_run_in && t1_nowr |=> $stable(t1_count))
		else $error("timer 1 count moved while stopped");

	AST_T0_GATE_HOLD: assert property (
		timer0_run_in && timer0_gate_en_in && !gate_act_a && t0_nowr
		|=> $stable(t0_count))
		else $error("timer 0 counted with its gate inactive");

	AST_T1_FAST16: assert property (
		timer1_run_in && !timer1_gate_en_in && !timer1_counter_select_in
		&& timer1_fastclk_sel_in && timer1_mode_in == gct_pkg::MODE_16 && t1_nowr
		|=> t1_count == $past(t1_count) + gct_pkg::CNT_ONE)
		else $error("timer 1 16-bit fast count wrong");

	AST_T1_WRAP16: assert property (
		step1 && timer1_mode_in == gct_pkg::MODE_16 && t1_count == gct_pkg::CNT_ONES
		&& t1_nowr |=> t1_count == gct_pkg::CNT_ZERO && timer1_overflow_flag_out)
		else $error("timer 1 16-bit wrap wrong");

	AST_T1_WRAP13: assert property (
		step1 && timer1_mode_in == gct_pkg::MODE_13 && t1_nowr
		&& timer1_high_byte_out == gct_pkg::BYTE_ONES && t1_low5 == gct_pkg::LOW5_ONES
		|=> timer1_high_byte_out == gct_pkg::BYTE_RST && t1_low5 == 5'h00
		&& timer1_overflow_flag_out)
		else $error("timer 1 13-bit wrap wrong");

	AST_T1_COUNT13: assert property (
		step1 && timer1_mode_in == gct_pkg::MODE_13 && t1_nowr
		&& t1_low5 != gct_pkg::LOW5_ONES
		|=> $stable(timer1_high_byte_out) && t1_low5 == $past(t1_low5) + gct_pkg::LOW5_ONE)
		else $error("timer 1 13-bit low field count wrong");

	AST_T0_RELOAD: assert property (
		step0 && timer0_mode_in == gct_pkg::MODE_8R && t0_nowr
		&& timer0_low_byte_out == gct_pkg::BYTE_ONES
		|=> timer0_low_byte_out == $past(timer0_high_byte_out) && timer0_overflow_flag_out)
		else $error("timer 0 auto-reload wrong");

	AST_T0_RELOAD_KEEP: assert property (
		timer0_mode_in == gct_pkg::MODE_8R && !timer0_high_wr_in
		|=> $stable(timer0_high_byte_out))
		else $error("timer 0 reload value changed");

	AST_T0_IRQ: assert property (
		timer0_irq_out == (timer0_overflow_flag_out && $past(timer0_irq_en_in)))
		else $error("timer 0 interrupt request mismatch");

	AST_T1_EVENT_ONLY: assert property (
		timer1_run_in && !timer1_gate_en_in && timer1_counter_select_in
		&& !st.fall[1] && t1_nowr |=> $stable(t1_count))
		else $error("timer 1 counted without an event edge");

	AST_T0_EVENT_STEP: assert property (
		timer0_run_in && !timer0_gate_en_in && timer0_counter_select_in && st.fall[0]
		&& timer0_mode_in == gct_pkg::MODE_16 && t0_nowr
		|=> t0_count == $past(t0_count) + gct_pkg::CNT_ONE)
		else $error("timer 0 missed an event edge");

	AST_T0_PRESC_WAIT: assert property (
		timer0_run_in && !timer0_counter_select_in && !timer0_fastclk_sel_in
		&& !st.presc_tick && t0_nowr |=> $stable(t0_count))
		else $error("timer 0 counted between prescaled ticks");

	AST_T0_WRITE_LOW: assert property (
		timer0_low_wr_in |=> timer0_low_byte_out == $past(timer0_wr_data_in))
		else $error("timer 0 low byte write lost");

	AST_T1_WRITE_HIGH: assert property (
		timer1_high_wr_in |=> timer1_high_byte_out == $past(timer1_wr_data_in))
		else $error("timer 1 high byte write lost");

	AST_T0_MODE_HOLD: assert property (
		timer0_mode_in == gct_pkg::MODE_SPLIT && t0_nowr |=> $stable(t0_count))
		else $error("timer 0 counted in the holding mode");

	AST_T1_SET_WINS: assert property (
		step1 && timer1_flag_clr_in && timer1_mode_in == gct_pkg::MODE_16
		&& t1_count == gct_pkg::CNT_ONES |=> timer1_overflow_flag_out)
		else $error("timer 1 overflow lost against clear");

	CV_T0_WRAP16: cover property (
		step0 && timer0_mode_in == gct_pkg::MODE_16 && t0_count == gct_pkg::CNT_ONES);

	CV_T1_RELOAD: cover property (
		step1 && timer1_mode_in == gct_pkg::MODE_8R
		&& timer1_low_byte_out == gct_pkg::BYTE_ONES);

	CV_T0_EVENT: cover property (
		step0 && timer0_counter_select_in);

	CV_T1_GATED: cover property (
		step1 && timer1_gate_en_in);

	CV_PRESC_EXT: cover property (
		st.presc_tick && st.presc_sel == gct_pkg::PSC_EXT8);
endmodule

// ==== pkg/gct_pkg.sv ====
// Purpose: shared constants for the gated counter/timer pair
// Assumes: one system clock, all control bits arrive as plain ports
// Notes:   mode, prescale and synchroniser codes live here
//
// Functional notes
// - each timer runs 13-bit, 16-bit or 8-bit auto-reload, chosen by mode bits
// - the two timers are configured independently, except the shared prescale select field
// - five clock sources from fast-clock select bit and prescale select field
// - count is 16 bits, read and written as low and high bytes
// - counter operation increments once per falling edge on the event pin
// - event rates to a quarter of sysclk; source holds levels two cycles
// - 13-bit mode: high byte is top eight bits, low bits 4..0 bottom
// - 13-bit mode: wrap from all ones to zero sets the overflow flag
// - interrupt request when overflow flag and interrupt enable are both set
// - counter-select 1 counts event pin falls, 0 counts the internal clock
// - fast-clock select 1 uses sysclk, 0 uses the prescaled clock
// - count only when run and (gate disabled or gate input active)
// - timer 1 gates on second input; each gate has its own polarity bit
// - setting run does not clear the count; software preloads it
// - timer 1 uses its own bytes and control bits exactly like timer 0
// - 16-bit mode is like 13-bit mode but uses all sixteen bits
// - 8-bit mode: low byte counts, on wrap flag set and reload from high
// - 8-bit mode: the high-byte reload value is never changed by counting
package gct_pkg;
	localparam logic [1:0] MODE_13    = 2'h0;
	localparam logic [1:0] MODE_16    = 2'h1;
	localparam logic [1:0] MODE_8R    = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	localparam logic [1:0] PSC_DIV12  = 2'h0;
	localparam logic [1:0] PSC_DIV4   = 2'h1;
	localparam logic [1:0] PSC_DIV48  = 2'h2;
	localparam logic [1:0] PSC_EXT8   = 2'h3;

	localparam int         PSC_W      = 6;
	localparam logic [5:0] LIM_DIV12  = 6'h0b;
	localparam logic [5:0] LIM_DIV4   = 6'h03;
	localparam logic [5:0] LIM_DIV48  = 6'h2f;
	localparam logic [5:0] LIM_EXT8   = 6'h07;
	localparam logic [5:0] PSC_ONE    = 6'h01;
	localparam logic [5:0] PSC_RST    = 6'h00;

	localparam int         SYN_EVA    = 0;
	localparam int         SYN_EVB    = 1;
	localparam int         SYN_GTA    = 2;
	localparam int         SYN_GTB    = 3;
	localparam int         SYN_EXT    = 4;
	localparam int         SYN_N      = 5;
	localparam int         SYN_S1     = 0;
	localparam int         SYN_S2     = 1;
	localparam int         SYN_S3     = 2;
	localparam int         SYN_D      = 3;

	localparam int         LOW13_W    = 5;
	localparam logic [7:0] BYTE_RST   = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hff;
	localparam logic [4:0] LOW5_ONES  = 5'h1f;
	localparam logic [4:0] LOW5_ONE   = 5'h01;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_ONES  = 16'hffff;
endpackage

// ==== verification/gct_pin_model.sv ====
// Purpose: far-side model of the event pins and gate inputs
// Assumes: fire_in is a one-cycle request, sent only while that pin is idle
// Notes:   each pulse holds low, then high, for hold_in cycles (2 = quarter rate)
`timescale 1ns/10ps
module gct_pin_model (
	input  wire logic       ref_clk_in,
	input  wire logic [1:0] fire_in,
	input  wire logic [3:0] hold_in,
	input  wire logic [1:0] gate_lvl_in,
	output logic      [1:0] event_pin_out,
	output logic      [1:0] gate_out,
	output logic      [1:0] busy_out
);
	logic [4:0] cnt [2];

	initial begin
		event_pin_out = 2'h3;
		gate_out      = 2'h0;
		cnt[0]        = 5'h00;
		cnt[1]        = 5'h00;
	end

	always @(posedge ref_clk_in) begin
		gate_out <= gate_lvl_in;
		for (int i = 0; i < 2; i++) begin
			if (cnt[i] != 5'h00) begin
				cnt[i] <= cnt[i] - 5'h01;
				if (cnt[i] == {1'b0, hold_in}) begin
					event_pin_out[i] <= 1'b1;
				end
			end else if (fire_in[i]) begin
				event_pin_out[i] <= 1'b0;
				cnt[i]           <= {hold_in, 1'b0} - 5'h01;
			end
		end
	end

	assign busy_out[0] = (cnt[0] != 5'h00) | !event_pin_out[0];
	assign busy_out[1] = (cnt[1] != 5'h00) | !event_pin_out[1];
endmodule

// ==== verification/gct_top_tb_top.sv ====
// Purpose: self-checking bench for the gated counter/timer pair
// Assumes: inputs driven by non-blocking assignment at the rising edge
// Notes:   runs are exact edge windows, so counts are exact
`timescale 1ns/10ps
module gct_top_tb_top;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] m [2], psel = 2'h0, fire = 2'h0, gl = 2'h0, bsy, evp, gat;
	logic       cs [2], ge [2], rn [2], fs [2], ie [2], lw [2], hw [2], fc [2], gp [2];
	logic [7:0] wd [2], lo [2], hi [2];
	logic       fl [2], iq [2];
	logic [3:0] hold = 4'h2;
	logic [4:0] osc = 5'h00;
	int         miscompares = 0;
	int         tests_run = 0;

	always #10 clk = ~clk;
	always @(posedge clk) osc <= osc + 5'h01;

	gct_pin_model pins (.ref_clk_in(clk), .fire_in(fire), .hold_in(hold), .gate_lvl_in(gl),
		.event_pin_out(evp), .gate_out(gat), .busy_out(bsy));

	gct_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .event_pin_a_in(evp[0]),
		.event_pin_b_in(evp[1]), .gate_input_a_in(gat[0]), .gate_input_b_in(gat[1]),
		.gate_input_a_polarity_in(gp[0]), .gate_input_b_polarity_in(gp[1]),
		.ext_osc_in(osc[1]), .prescale_select_in(psel),
		.timer0_mode_in(m[0]), .timer0_counter_select_in(cs[0]), .timer0_gate_en_in(ge[0]),
		.timer0_run_in(rn[0]), .timer0_fastclk_sel_in(fs[0]), .timer0_irq_en_in(ie[0]),
		.timer0_low_wr_in(lw[0]), .timer0_high_wr_in(hw[0]), .timer0_wr_data_in(wd[0]),
		.timer0_flag_clr_in(fc[0]), .timer1_mode_in(m[1]), .timer1_counter_select_in(cs[1]),
		.timer1_gate_en_in(ge[1]), .timer1_run_in(rn[1]), .timer1_fastclk_sel_in(fs[1]),
		.timer1_irq_en_in(ie[1]), .timer1_low_wr_in(lw[1]), .timer1_high_wr_in(hw[1]),
		.timer1_wr_data_in(wd[1]), .timer1_flag_clr_in(fc[1]),
		.timer0_low_byte_out(lo[0]), .timer0_high_byte_out(hi[0]),
		.timer0_overflow_flag_out(fl[0]), .timer0_irq_out(iq[0]),
		.timer1_low_byte_out(lo[1]), .timer1_high_byte_out(hi[1]),
		.timer1_overflow_flag_out(fl[1]), .timer1_irq_out(iq[1]));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [16:0] exp_cnt(logic [1:0] md, logic [15:0] st, int n);
		logic [15:0] v;
		logic [12:0] c;
		logic        f;
		v = st;
		f = 1'b0;
		for (int i = 0; i < n; i++) begin
			case (md)
				gct_pkg::MODE_13: begin
					c = {v[15:8], v[4:0]};
					f = f | (&c);
					c = c + 13'h0001;
					v = {c[12:5], v[7:5], c[4:0]};
				end
				gct_pkg::MODE_16: begin
					f = f | (&v);
					v = v + 16'h0001;
				end
				gct_pkg::MODE_8R: begin
					if (&v[7:0]) begin
						f = 1'b1;
						v[7:0] = v[15:8];
					end else begin
						v[7:0] = v[7:0] + 8'h01;
					end
				end
				default: ;
			endcase
		end
		return {f, v};
	endfunction

	task automatic wr(input int t, input logic [15:0] v);
		@(posedge clk);
		wd[t] <= v[7:0];
		lw[t] <= 1'b1;
		fc[t] <= 1'b1;
		@(posedge clk);
		lw[t] <= 1'b0;
		fc[t] <= 1'b0;
		hw[t] <= 1'b1;
		wd[t] <= v[15:8];
		@(posedge clk);
		hw[t] <= 1'b0;
	endtask

	task automatic run_n(input int n);
		@(posedge clk);
		rn[0] <= 1'b1;
		rn[1] <= 1'b1;
		repeat (n) @(posedge clk);
		rn[0] <= 1'b0;
		rn[1] <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && bsy !== 2'h0; i++) @(posedge clk);
		if (i == 200) begin
			miscompares++;
			test_done();
		end
	endtask

	initial begin
		logic [15:0] st [2];
		logic [1:0]  md [2];
		int          n;
		int          k [2];
		logic [16:0] e;
		for (int t = 0; t < 2; t++) begin
			m[t] = 2'h0; cs[t] = 1'b0; ge[t] = 1'b0; rn[t] = 1'b0; fs[t] = 1'b1; ie[t] = 1'b0;
			lw[t] = 1'b0; hw[t] = 1'b0; fc[t] = 1'b0; gp[t] = 1'b0; wd[t] = 8'h00;
		end
		void'($urandom(32'h81f1));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		for (int t = 0; t < 2; t++) chk("reset", {fl[t] | iq[t], hi[t], lo[t]}, 17'h0_0000);
		$display("test reset done");
		// random modes on both timers at once, near-wrap starts among them
		for (int r = 0; r < 24; r++) begin
			for (int t = 0; t < 2; t++) begin
				md[t] = 2'($urandom % 4);
				st[t] = ($urandom % 2) ? {12'hfff, 4'($urandom)} : 16'($urandom);
				m[t]  <= md[t];
				ie[t] <= 1'($urandom);
				wr(t, st[t]);
			end
			n = 1 + $urandom % 40;
			run_n(n);
			for (int t = 0; t < 2; t++) begin
				e = exp_cnt(md[t], st[t], n);
				chk("count", {fl[t], hi[t], lo[t]}, e);
				chk("irq", 17'(iq[t]), 17'(e[16] & ie[t]));
			end
		end
		$display("test modes done");
		// prescaled internal clocks, one window per source
		for (int p = 0; p < 4; p++) begin
			psel <= 2'(p);
			for (int t = 0; t < 2; t++) begin
				m[t]  <= gct_pkg::MODE_16;
				fs[t] <= 1'b0;
				wr(t, 16'h0000);
			end
			repeat (64) @(posedge clk);
			n = (p == 2) ? 96 : ((p == 3) ? 128 : 48);
			run_n(n);
			for (int t = 0; t < 2; t++) begin
				chk("prescale", {fl[t], hi[t], lo[t]}, 17'((p == 1) ? 12 : ((p == 2) ? 2 : 4)));
			end
		end
		$display("test prescale done");
		// event pin falls, prompt and slow far side, fast select ignored
		for (int h = 0; h < 2; h++) begin
			hold <= h ? 4'h5 : 4'h2;
			for (int t = 0; t < 2; t++) begin
				cs[t] <= 1'b1;
				fs[t] <= 1'($urandom);
				k[t]  = 1 + $urandom % 6;
				st[t] = 16'($urandom);
				wr(t, st[t]);
			end
			@(posedge clk);
			rn[0] <= 1'b1;
			rn[1] <= 1'b1;
			repeat (8) @(posedge clk);
			for (int i = 0; i < k[0] + k[1]; i++) begin
				wait_idle();
				fire <= (i < k[0]) ? 2'h1 : 2'h2;
				@(posedge clk);
				fire <= 2'h0;
				@(posedge clk);
			end
			wait_idle();
			repeat (4) @(posedge clk);
			run_n(4);
			for (int t = 0; t < 2; t++) begin
				chk("events", {fl[t], hi[t], lo[t]}, exp_cnt(gct_pkg::MODE_16, st[t], k[t]));
			end
		end
		$display("test events done");
		// gate enable, gate level and polarity combinations
		for (int c = 0; c < 8; c++) begin
			for (int t = 0; t < 2; t++) begin
				cs[t] <= 1'b0;
				fs[t] <= 1'b1;
				ge[t] <= c[2];
				gp[t] <= c[1];
				gl[t] <= c[0];
				wr(t, 16'h0000);
			end
			repeat (8) @(posedge clk);
			run_n(20);
			for (int t = 0; t < 2; t++) begin
				chk("gate", {fl[t], hi[t], lo[t]}, (!c[2] || c[1] == c[0]) ? 17'd20 : 17'd0);
			end
		end
		$display("test gating done");
		test_done();
	end
endmodule
